// File: rtl/ttc_pkg.sv
// constants and carrier types for the triple timer/counter block
package ttc_pkg;

  // ****************************************************
  // register byte addresses
  // ****************************************************
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_C0L = 8'h08;
  localparam logic [7:0] OFF_C0H = 8'h0C;
  localparam logic [7:0] OFF_C1L = 8'h10;
  localparam logic [7:0] OFF_C1H = 8'h14;
  localparam logic [7:0] OFF_COUNTER_TWO_CONTROL = 8'h18;
  localparam logic [7:0] OFF_COUNTER_TWO_MODE_REG = 8'h1C;
  localparam logic [7:0] OFF_RLL = 8'h20;
  localparam logic [7:0] OFF_RLH = 8'h24;
  localparam logic [7:0] OFF_C2L = 8'h28;
  localparam logic [7:0] OFF_C2H = 8'h2C;
  localparam logic [7:0] OFF_STS = 8'h30;
  localparam logic [7:0] OFF_MSK = 8'h34;
  localparam logic [7:0] OFF_CFG = 8'h38;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int MD0_GATE = 3;
  localparam int MD0_CT = 2;
  localparam int MD1_GATE = 7;
  localparam int MD1_CT = 6;
  localparam int CTL_TF1 = 7;
  localparam int CTL_TR1 = 6;
  localparam int CTL_TF0 = 5;
  localparam int CTL_TR0 = 4;
  localparam int T2_TF2 = 7;
  localparam int T2_EXF2 = 6;
  localparam int T2_RCLK = 5;
  localparam int T2_TCLK = 4;
  localparam int T2_EXEN2 = 3;
  localparam int T2_TR2 = 2;
  localparam int T2_CT2 = 1;
  localparam int T2_CPRL2 = 0;
  localparam int T2M_OE = 1;
  localparam int STS_OV0 = 0;
  localparam int STS_OV1 = 1;
  localparam int STS_OV2 = 2;
  localparam int STS_EXT2 = 3;
  localparam int CFG_SIX = 0;

  // ****************************************************
  // modes and timing
  // ****************************************************
  localparam logic [1:0] MD_13 = 2'h0;
  localparam logic [1:0] MD_16 = 2'h1;
  localparam logic [1:0] MD_AR8 = 2'h2;
  localparam logic [1:0] MD_SPLIT = 2'h3;
  localparam logic [3:0] MC_CLK12 = 4'hC;
  localparam logic [3:0] MC_CLK6 = 4'h6;
  localparam logic [4:0] MAX13_LO = 5'h1F;
  localparam logic [7:0] MAX8 = 8'hFF;
  localparam logic [15:0] MAX16 = 16'hFFFF;
  localparam int PIN_W = 6;
  localparam int PIN_CNT0 = 0;
  localparam int PIN_CNT1 = 1;
  localparam int PIN_EXT_IRQ_PIN_ZERO = 2;
  localparam int PIN_EXT_IRQ_PIN_ONE = 3;
  localparam int PIN_TRIG = 4;
  localparam int PIN_CLK2 = 5;

  // ****************************************************
  // complete block state
  // ****************************************************
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [7:0] c0l;
    logic [7:0] c0h;
    logic [7:0] c1l;
    logic [7:0] c1h;
    logic [7:0] counter_two_control;
    logic [7:0] counter_two_mode_reg;
    logic [7:0] rll;
    logic [7:0] rlh;
    logic [7:0] c2l;
    logic [7:0] c2h;
    logic [3:0] sts;
    logic [3:0] msk;
    logic six_clk;
    logic gate0_on;
    logic gate1_on;
    logic clkout;
    logic clkoe;
    logic baud_tick;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } ttc_state_t;

endpackage

// File: rtl/ttc_sync.sv
// three-stage pin synchroniser with filtered level and falling-edge pulse
module ttc_sync import ttc_pkg::*; #(
  parameter int W = PIN_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] fall_o
);

  // ****************************************************
  // per pin: a change counts once stages two and three agree
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      logic fall_ff;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_ff <= 1'b1;
          s2_ff <= 1'b1;
          s3_ff <= 1'b1;
          lvl_ff <= 1'b1;
          fall_ff <= 1'b0;
        end else begin
          s1_ff <= pin_i[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          fall_ff <= (s2_ff == s3_ff) && lvl_ff && !s2_ff;
          if (s2_ff == s3_ff) begin
            lvl_ff <= s2_ff;
          end
        end
      end
      assign level_o[g] = lvl_ff;
      assign fall_o[g] = fall_ff;
    end
  endgenerate

endmodule

// File: rtl/ttc_prescale.sv
// machine-cycle and osc/2 or osc/1 tick generator for 12 or 6 clocks per cycle
module ttc_prescale import ttc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic six_clk_i,
  output logic mc_tick_o,
  output logic fast_tick_o
);

  logic [3:0] cnt_ff;
  logic [3:0] lim;

  assign lim = six_clk_i ? MC_CLK6 : MC_CLK12;
  assign mc_tick_o = (cnt_ff == lim - 4'h1);
  // clock-out and baud modes count at osc/2 or osc/1
  assign fast_tick_o = six_clk_i | cnt_ff[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 4'h0;
    end else if (mc_tick_o || cnt_ff >= lim) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

endmodule

// File: rtl/ttc_top.sv
// three 16-bit timer/counters with clock output behind a wishbone slave
// Contract
// - three 16-bit counters as byte pairs
// - counter zero mode from mode low nibble
// - internal control runs counter zero by run bit
// - gated zero toggles on pin zero fall
// - counter one mode from high nibble
// - counter one run bit, gated by pin one
// - counter two control and mode register select its mode
// - without trigger, reload only on overflow
// - trigger pin fall reloads/captures, not baud
// - shared pin is count input or clock
// - clock out toggles each reload overflow
// - clock-out and baud roll-overs raise no overflow flag
// - baud and clock out run together
// - default twelve clocks, six on command
module ttc_top import ttc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_pin_zero_i,
  input wire logic count_pin_one_i,
  input wire logic ext_irq_pin_zero_n_i,
  input wire logic ext_irq_pin_one_n_i,
  input wire logic counter_two_trigger_pin_n_i,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  output logic baud_tick_o,
  output logic irq_o
);

  ttc_state_t s;
  ttc_state_t n;
  logic [PIN_W-1:0] fall;
  logic mc_tick;
  logic fast_tick;
  logic wr_stb;
  logic rd_stb;
  logic [1:0] m0;
  logic [1:0] m1;
  logic inc0;
  logic inc1;
  logic inc2;
  logic t2_baud;
  logic t2_clko;
  logic t2_fast;
  logic trig2;

  // ****************************************************
  // pins and time base
  // ****************************************************
  ttc_sync #(.W(PIN_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({clk_pin_i, counter_two_trigger_pin_n_i, ext_irq_pin_one_n_i,
            ext_irq_pin_zero_n_i, count_pin_one_i, count_pin_zero_i}),
    .level_o(),
    .fall_o(fall)
  );

  ttc_prescale u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .six_clk_i(s.six_clk),
    .mc_tick_o(mc_tick),
    .fast_tick_o(fast_tick)
  );

  // ****************************************************
  // step of an 8/13/16-bit counter pair: {ovf, hi, lo}
  // ****************************************************
  function automatic logic [16:0] step(input logic [1:0] md,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [5:0] l5;
    logic [8:0] h9;
    logic [8:0] l9;
    logic [16:0] r;
    l5 = {1'b0, lo[4:0]} + 6'h01;
    h9 = {1'b0, hi} + {8'h00, l5[5]};
    l9 = {1'b0, lo} + 9'h001;
    case (md)
      MD_13: r = {h9, lo[7:5], l5[4:0]};
      MD_16: r = {1'b0, hi, lo} + 17'h00001;
      MD_AR8: r = {l9[8], hi, (l9[8] ? hi : l9[7:0])};
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  // ****************************************************
  // register read mux
  // ****************************************************
  function automatic logic [7:0] rd(input ttc_state_t q,
                                    input logic [7:0] a);
    logic [7:0] v;
    case (a)
      OFF_MODE: v = q.mode;
      OFF_CTRL: v = q.ctrl;
      OFF_C0L: v = q.c0l;
      OFF_C0H: v = q.c0h;
      OFF_C1L: v = q.c1l;
      OFF_C1H: v = q.c1h;
      OFF_COUNTER_TWO_CONTROL: v = q.counter_two_control;
      OFF_COUNTER_TWO_MODE_REG: v = q.counter_two_mode_reg;
      OFF_RLL: v = q.rll;
      OFF_RLH: v = q.rlh;
      OFF_C2L: v = q.c2l;
      OFF_C2H: v = q.c2h;
      OFF_STS: v = {4'h0, q.sts};
      OFF_MSK: v = {4'h0, q.msk};
      OFF_CFG: v = {7'h00, q.six_clk};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************************
  // count enables
  // ****************************************************
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;
  assign rd_stb = wb_cyc_i & wb_stb_i & !wb_we_i & s.ack;
  assign m0 = s.mode[1:0];
  assign m1 = s.mode[5:4];
  // run by bit, gate toggle, edge or cycle
  assign inc0 = s.ctrl[CTL_TR0] & (!s.mode[MD0_GATE] | s.gate0_on) &
                (s.mode[MD0_CT] ? fall[PIN_CNT0] : mc_tick);
  // counter one halts in mode three
  assign inc1 = s.ctrl[CTL_TR1] & (!s.mode[MD1_GATE] | s.gate1_on) &
                (m1 != MD_SPLIT) &
                (s.mode[MD1_CT] ? fall[PIN_CNT1] : mc_tick);
  assign t2_baud = s.counter_two_control[T2_RCLK] | s.counter_two_control[T2_TCLK];
  assign t2_clko = s.counter_two_mode_reg[T2M_OE] & !s.counter_two_control[T2_CT2];
  // both fast modes share one count chain
  assign t2_fast = t2_baud | t2_clko;
  // shared pin is the count input when selected
  assign inc2 = s.counter_two_control[T2_TR2] & (s.counter_two_control[T2_CT2] ? fall[PIN_CLK2] :
                (t2_fast ? fast_tick : mc_tick));
  // trigger ignored while generating a baud rate
  assign trig2 = s.counter_two_control[T2_EXEN2] & !t2_baud & fall[PIN_TRIG];

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    logic [16:0] r;
    logic [8:0] h9;
    logic [16:0] c2;
    logic [3:0] set;
    r = 17'h00000;
    h9 = 9'h000;
    c2 = 17'h00000;
    set = 4'h0;
    n = s;
    n.baud_tick = 1'b0;
    // falling edge on pin zero switches gated counter
    if (!s.ctrl[CTL_TR0]) begin
      n.gate0_on = 1'b0;
    end else if (fall[PIN_EXT_IRQ_PIN_ZERO]) begin
      n.gate0_on = !s.gate0_on;
    end
    // falling edge on pin one switches gated counter
    if (!s.ctrl[CTL_TR1]) begin
      n.gate1_on = 1'b0;
    end else if (fall[PIN_EXT_IRQ_PIN_ONE]) begin
      n.gate1_on = !s.gate1_on;
    end
    if (inc0) begin
      if (m0 == MD_SPLIT) begin
        h9 = {1'b0, s.c0l} + 9'h001;
        r = {h9[8], s.c0h, h9[7:0]};
      end else begin
        r = step(m0, s.c0l, s.c0h);
      end
      n.c0l = r[7:0];
      n.c0h = r[15:8];
      set[STS_OV0] = r[16];
    end
    // upper half of split counter zero runs on run bit one
    if (m0 == MD_SPLIT && s.ctrl[CTL_TR1] && mc_tick) begin
      h9 = {1'b0, s.c0h} + 9'h001;
      n.c0h = h9[7:0];
      set[STS_OV1] = h9[8];
    end
    // counter one, its flag taken while zero is split
    if (inc1) begin
      r = step(m1, s.c1l, s.c1h);
      n.c1l = r[7:0];
      n.c1h = r[15:8];
      set[STS_OV1] = set[STS_OV1] | (r[16] & (m0 != MD_SPLIT));
    end
    // counter two reloads on overflow unless capturing outside the fast modes
    if (inc2) begin
      c2 = {1'b0, s.c2h, s.c2l} + 17'h00001;
      {n.c2h, n.c2l} = c2[15:0];
      if (c2[16]) begin
        if (!s.counter_two_control[T2_CPRL2] || t2_fast) begin
          {n.c2h, n.c2l} = {s.rlh, s.rll};
        end
        // no flag in clock-out or baud modes
        set[STS_OV2] = !t2_fast;
        // toggling per overflow halves the rate again
        n.clkout = t2_clko ? !s.clkout : 1'b0;
        n.baud_tick = t2_baud;
      end
    end
    if (trig2) begin
      if (s.counter_two_control[T2_CPRL2]) begin
        {n.rlh, n.rll} = {s.c2h, s.c2l};
      end else begin
        {n.c2h, n.c2l} = {s.rlh, s.rll};
      end
      set[STS_EXT2] = 1'b1;
    end
    if (!t2_clko) begin
      n.clkout = 1'b0;
    end
    // pin drives only in clock-out mode
    n.clkoe = t2_clko;
    // software writes override counting, low byte lane only
    if (wr_stb && wb_sel_i[0]) begin
      case (wb_adr_i)
        OFF_MODE: n.mode = wb_dat_i[7:0];
        OFF_CTRL: n.ctrl = wb_dat_i[7:0];
        OFF_C0L: n.c0l = wb_dat_i[7:0];
        OFF_C0H: n.c0h = wb_dat_i[7:0];
        OFF_C1L: n.c1l = wb_dat_i[7:0];
        OFF_C1H: n.c1h = wb_dat_i[7:0];
        OFF_COUNTER_TWO_CONTROL: n.counter_two_control = wb_dat_i[7:0];
        OFF_COUNTER_TWO_MODE_REG: n.counter_two_mode_reg = wb_dat_i[7:0];
        OFF_RLL: n.rll = wb_dat_i[7:0];
        OFF_RLH: n.rlh = wb_dat_i[7:0];
        OFF_C2L: n.c2l = wb_dat_i[7:0];
        OFF_C2H: n.c2h = wb_dat_i[7:0];
        OFF_MSK: n.msk = wb_dat_i[3:0];
        // six-clock command can only be switched on
        OFF_CFG: n.six_clk = s.six_clk | wb_dat_i[CFG_SIX];
        default: n.mode = n.mode;
      endcase
    end
    if (rd_stb && wb_adr_i == OFF_STS) begin
      n.sts = 4'h0;
    end
    // hardware sets win over any clear
    n.ctrl[CTL_TF0] = n.ctrl[CTL_TF0] | set[STS_OV0];
    n.ctrl[CTL_TF1] = n.ctrl[CTL_TF1] | set[STS_OV1];
    n.counter_two_control[T2_TF2] = n.counter_two_control[T2_TF2] | set[STS_OV2];
    n.counter_two_control[T2_EXF2] = n.counter_two_control[T2_EXF2] | set[STS_EXT2];
    n.sts = n.sts | set;
    n.irq = |(n.sts & n.msk);
    // bus: answer one cycle after the request, drop after one
    n.ack = wb_cyc_i & wb_stb_i & !s.ack;
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      n.dat = {24'h000000, rd(s, wb_adr_i)};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign clk_pin_o = s.clkout;
  assign clk_pin_oe_o = s.clkoe;
  assign baud_tick_o = s.baud_tick;
  assign irq_o = s.irq;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_sts_read;
    rd_stb && wb_adr_i == OFF_STS && !inc0 && !inc1 && !inc2 && !trig2 &&
    !mc_tick;
  endsequence

  sequence s_t0_wrap16;
    inc0 && m0 == MD_16 && {s.c0h, s.c0l} == MAX16 && !wr_stb;
  endsequence

  a_ack_single: assert property (s.ack |=> !s.ack)
    else $error("ack held longer than one cycle");
  a_t0_stopped: assert property (
    (!s.ctrl[CTL_TR0] && !wr_stb) |=> $stable(s.c0l))
    else $error("counter zero moved while run bit clear");
  a_t0_reload8: assert property (
    (inc0 && m0 == MD_AR8 && s.c0l == MAX8 && !wr_stb)
    |=> s.c0l == $past(s.c0h))
    else $error("counter zero missed 8-bit reload");
  a_gate_toggle: assert property (
    (s.ctrl[CTL_TR0] && fall[PIN_EXT_IRQ_PIN_ZERO] && !wr_stb)
    |=> s.gate0_on != $past(s.gate0_on))
    else $error("gate zero did not switch on pin fall");
  a_t1_split_halt: assert property (
    (m1 == MD_SPLIT && !wr_stb) |=> $stable({s.c1h, s.c1l}))
    else $error("counter one ran in mode three");
  a_t0_event_step: assert property (
    (inc0 && m0 == MD_16 && {s.c0h, s.c0l} != MAX16 && !wr_stb)
    |=> {s.c0h, s.c0l} == $past({s.c0h, s.c0l}) + 16'h0001)
    else $error("counter zero did not step by one");
  a_t0_ovf_flag: assert property (
    s_t0_wrap16 |=> s.ctrl[CTL_TF0] && s.sts[STS_OV0] &&
    (s.irq || !s.msk[STS_OV0]))
    else $error("counter zero wrap not flagged");
  a_t2_reload: assert property (
    (inc2 && {s.c2h, s.c2l} == MAX16 && !s.counter_two_control[T2_CPRL2] && !trig2 &&
     !wr_stb) |=> {s.c2h, s.c2l} == $past({s.rlh, s.rll}))
    else $error("counter two missed overflow reload");
  a_t2_trig_flag: assert property (
    (trig2 && !wr_stb) |=> s.counter_two_control[T2_EXF2] && s.sts[STS_EXT2])
    else $error("trigger edge not flagged");
  a_t2_quiet_flag: assert property (
    (t2_fast && !trig2 && !wr_stb) |=> !$rose(s.counter_two_control[T2_TF2]))
    else $error("counter two flagged in clock-out or baud mode");
  a_clko_toggle: assert property (
    (t2_clko && inc2 && {s.c2h, s.c2l} == MAX16 && !wr_stb)
    |=> s.clkout != $past(s.clkout) && s.clkoe)
    else $error("clock output did not toggle on overflow");
  a_tick_space: assert property (
    (mc_tick && !s.six_clk) |=> !mc_tick [*5])
    else $error("machine tick spacing too short");
  a_sts_clear: assert property (s_sts_read |=> s.sts == 4'h0 && !s.irq)
    else $error("status read did not clear");

endmodule

// File: verif/ttc_pin_model.sv
// pin-side partner: count, gate, trigger and shared clock pins
module ttc_pin_model import ttc_pkg::*; (
  input wire logic clk_i,
  input wire logic clock_out_i,
  input wire logic clock_oe_i,
  output logic [PIN_W-1:0] pins_o,
  output logic clk_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle high behind pull-ups
  logic [PIN_W-1:0] pins_ff = {PIN_W{1'b1}};
  assign pins_o = pins_ff;
  assign clk_line_o = clock_oe_i ? clock_out_i : pins_ff[PIN_CLK2];
  task automatic fall(input int idx);
    @(posedge clk_i);
    pins_ff[idx] <= 1'b0;
    repeat (4) @(posedge clk_i);
    pins_ff[idx] <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// File: verif/ttc_top_bench.sv
// self-checking bench for the triple timer/counter block
module ttc_top_bench import ttc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack, line, pin_o, oe, baud, irq;
  logic [PIN_W-1:0] pins;
  int errors = 0;
  int comparisons = 0;
  int nb, hp;

  always #5 clk_i = ~clk_i;

  ttc_top i_ttc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .count_pin_zero_i(pins[PIN_CNT0]), .count_pin_one_i(pins[PIN_CNT1]),
    .ext_irq_pin_zero_n_i(pins[PIN_EXT_IRQ_PIN_ZERO]),
    .ext_irq_pin_one_n_i(pins[PIN_EXT_IRQ_PIN_ONE]),
    .counter_two_trigger_pin_n_i(pins[PIN_TRIG]), .clk_pin_i(line),
    .clk_pin_o(pin_o), .clk_pin_oe_o(oe), .baud_tick_o(baud), .irq_o(irq));

  ttc_pin_model i_ttc_pin_model (.clk_i(clk_i), .clock_out_i(pin_o),
    .clock_oe_i(oe), .pins_o(pins), .clk_line_o(line));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp,
          input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask

  task fall(input int idx);
    i_ttc_pin_model.fall(idx);
  endtask

  // cycles between two changes of the clock-out pin
  task half(output int n);
    logic p;
    int k;
    n = 0;
    @(posedge clk_i);
    p = pin_o;
    for (k = 0; k < 200 && pin_o === p; k++) @(posedge clk_i);
    p = pin_o;
    do begin
      @(posedge clk_i);
      n++;
    end while (pin_o === p && n < 200);
  endtask

  // pulse ignored while gate off, two counted while on, none once off again
  task gate(input logic [7:0] md, input logic [7:0] run, input int cp,
            input int gp, input logic [7:0] a);
    wr(OFF_MODE, md);
    wr(a, 32'h0);
    wr(a + 8'h04, 32'h0);
    wr(OFF_CTRL, run);
    fall(cp);
    fall(gp);
    fall(cp);
    fall(cp);
    fall(gp);
    fall(cp);
    wr(OFF_CTRL, 32'h0);
    rd(a, 32'h2);
  endtask

  task end_sim;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_sim;
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFF_C2H, 32'h0);
    rd(8'h3C, 32'h0);
    $display("test reset done");
    wr(OFF_C0L, 32'hFE);
    wr(OFF_C0H, 32'hFF);
    wr(OFF_MODE, 32'h01);
    wr(OFF_MSK, 32'h1);
    wr(OFF_CTRL, 32'h10);
    repeat (40) @(posedge clk_i);
    rd(OFF_CTRL, 32'h30);
    chk(irq, 1'b1);
    rd(OFF_STS, 32'h1);
    rd(OFF_STS, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_C0L, 32'h55);
    repeat (50) @(posedge clk_i);
    rd(OFF_C0L, 32'h55);
    $display("test timer zero done");
    wr(OFF_MODE, 32'h05);
    wr(OFF_C0L, 32'h0);
    wr(OFF_CTRL, 32'h10);
    repeat (3) fall(PIN_CNT0);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_C0L, 32'h3);
    wr(OFF_MODE, 32'h04);
    wr(OFF_C0H, 32'h12);
    wr(OFF_C0L, 32'hFF);
    wr(OFF_CTRL, 32'h10);
    fall(PIN_CNT0);
    rd(OFF_C0L, 32'hE0);
    rd(OFF_C0H, 32'h13);
    wr(OFF_MODE, 32'h06);
    wr(OFF_C0H, 32'h40);
    wr(OFF_C0L, 32'hFF);
    fall(PIN_CNT0);
    rd(OFF_CTRL, 32'h30);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_C0L, 32'h40);
    rd(OFF_STS, 32'h1);
    wr(OFF_MODE, 32'h03);
    wr(OFF_C0H, 32'hFF);
    wr(OFF_C0L, 32'h55);
    wr(OFF_CTRL, 32'h40);
    repeat (30) @(posedge clk_i);
    rd(OFF_CTRL, 32'hC0);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_C0L, 32'h55);
    rd(OFF_STS, 32'h2);
    wr(OFF_MODE, 32'h30);
    wr(OFF_C1L, 32'h77);
    wr(OFF_CTRL, 32'h40);
    repeat (60) @(posedge clk_i);
    rd(OFF_C1L, 32'h77);
    gate(8'h0D, 8'h10, PIN_CNT0, PIN_EXT_IRQ_PIN_ZERO, OFF_C0L);
    gate(8'hD0, 8'h40, PIN_CNT1, PIN_EXT_IRQ_PIN_ONE, OFF_C1L);
    $display("test counting done");
    wr(OFF_RLL, 32'h10);
    wr(OFF_RLH, 32'h20);
    wr(OFF_C2L, 32'hFF);
    wr(OFF_C2H, 32'hFF);
    wr(OFF_COUNTER_TWO_CONTROL, 32'h0A);
    fall(PIN_CLK2);
    rd(OFF_C2L, 32'hFF);
    wr(OFF_COUNTER_TWO_CONTROL, 32'h0E);
    fall(PIN_CLK2);
    rd(OFF_C2L, 32'h10);
    rd(OFF_C2H, 32'h20);
    rd(OFF_COUNTER_TWO_CONTROL, 32'h8E);
    wr(OFF_COUNTER_TWO_CONTROL, 32'h0E);
    wr(OFF_C2L, 32'h33);
    fall(PIN_TRIG);
    rd(OFF_C2L, 32'h10);
    rd(OFF_COUNTER_TWO_CONTROL, 32'h4E);
    rd(OFF_STS, 32'hC);
    wr(OFF_COUNTER_TWO_CONTROL, 32'h06);
    wr(OFF_C2L, 32'h33);
    fall(PIN_TRIG);
    fall(PIN_CLK2);
    rd(OFF_C2L, 32'h34);
    wr(OFF_COUNTER_TWO_CONTROL, 32'h0F);
    fall(PIN_TRIG);
    rd(OFF_RLL, 32'h34);
    wr(OFF_C2L, 32'hFF);
    wr(OFF_C2H, 32'hFF);
    fall(PIN_CLK2);
    rd(OFF_C2H, 32'h0);
    rd(OFF_COUNTER_TWO_CONTROL, 32'hCF);
    rd(OFF_STS, 32'hC);
    $display("test counter two done");
    wr(OFF_COUNTER_TWO_CONTROL, 32'h0);
    wr(OFF_RLL, 32'hFE);
    wr(OFF_RLH, 32'hFF);
    wr(OFF_C2L, 32'hFE);
    wr(OFF_C2H, 32'hFF);
    wr(OFF_COUNTER_TWO_MODE_REG, 32'h02);
    wr(OFF_COUNTER_TWO_CONTROL, 32'h04);
    repeat (4) @(posedge clk_i);
    chk(oe, 1'b1);
    half(hp);
    chk(hp, 4 * (65536 - 16'hFFFE) / 2);
    wr(OFF_COUNTER_TWO_CONTROL, 32'h3C);
    fall(PIN_TRIG);
    rd(OFF_COUNTER_TWO_CONTROL, 32'h0, 32'h40);
    nb = 0;
    repeat (80) begin
      @(posedge clk_i);
      if (baud === 1'b1) nb++;
    end
    chk(nb, 20);
    half(hp);
    chk(hp, 4);
    rd(OFF_STS, 32'h0, 32'h4);
    wr(OFF_CFG, 32'h1);
    half(hp);
    half(hp);
    chk(hp, 2 * (65536 - 16'hFFFE) / 2);
    wr(OFF_COUNTER_TWO_CONTROL, 32'h0);
    wr(OFF_COUNTER_TWO_MODE_REG, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(oe, 1'b0);
    $display("test clock out done");
    end_sim;
  end
endmodule
